//--- core/itc_pkg.sv
// Purpose: constants for the interrupt and trap control register block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   register offsets are byte addresses
package itc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] ITC_TRAP_CTRL_OFS  = 12'h000;
  localparam logic [11:0] ITC_GLOBAL_OFS     = 12'h004;
  localparam logic [11:0] ITC_SOFT_TRAP_OFS  = 12'h008;
  localparam logic [11:0] ITC_HARD_TRAP_OFS  = 12'h00c;
  localparam logic [11:0] ITC_VECTOR_OFS     = 12'h010;
  localparam logic [11:0] ITC_CPU_PRIO_OFS   = 12'h014;

  // ************************************************************
  // trap control and status fields
  // ************************************************************
  localparam int ITC_NEST_DIS_BIT   = 15;
  localparam int ITC_OVA_FLAG_BIT   = 14;
  localparam int ITC_OVB_FLAG_BIT   = 13;
  localparam int ITC_COVA_FLAG_BIT  = 12;
  localparam int ITC_COVB_FLAG_BIT  = 11;
  localparam int ITC_OVA_TE_BIT     = 10;
  localparam int ITC_OVB_TE_BIT     = 9;
  localparam int ITC_COV_TE_BIT     = 8;
  localparam int ITC_SHIFT_ERR_BIT  = 7;
  localparam int ITC_DIV0_ERR_BIT   = 6;
  localparam int ITC_DMAC_FLAG_BIT  = 5;
  localparam int ITC_MATH_ERR_BIT   = 4;
  localparam int ITC_ADDR_ERR_BIT   = 3;
  localparam int ITC_STACK_ERR_BIT  = 2;
  localparam int ITC_OSC_FAIL_BIT   = 1;
  localparam logic [15:0] ITC_TRAP_CTRL_MASK = 16'hfffe;
  localparam logic [15:0] ITC_TRAP_CTRL_RST  = 16'h0000;

  // ************************************************************
  // global control fields
  // ************************************************************
  localparam int ITC_GIE_BIT        = 15;
  localparam int ITC_IRQ_DISABLE_INSTR_ACTIVE_BIT       = 14;
  localparam int ITC_SOFTWARE_TRAP_EN_BIT  = 13;
  localparam int ITC_EXT_IRQS       = 3;
  localparam logic [15:0] ITC_GLOBAL_MASK = 16'he007;
  localparam logic [15:0] ITC_GLOBAL_RST  = 16'h8000;

  // ************************************************************
  // soft and hard trap fields
  // ************************************************************
  localparam int ITC_DMA_ADDR_BIT   = 5;
  localparam int ITC_LOOP_OVF_BIT   = 4;
  localparam logic [15:0] ITC_SOFT_TRAP_MASK = 16'h0030;
  localparam int ITC_SW_HARD_BIT    = 0;
  localparam logic [15:0] ITC_HARD_TRAP_MASK = 16'h0001;

  // ************************************************************
  // vector status fields
  // ************************************************************
  localparam int ITC_PRIO_W     = 4;
  localparam int ITC_VEC_W      = 8;
  localparam int ITC_PRIO_LSB   = 8;
  localparam int ITC_LOW_PRIO_W = 3;
  localparam logic [7:0] ITC_VEC_RST = 8'h00;
  localparam logic [3:0] ITC_PRIO_RST = 4'h0;

  // idle and busy states; no logic uses this type
  typedef enum logic [1:0] {
    ITC_IDLE_T,
    ITC_BUSY_T
  } itc_unused_t;

endpackage : itc_pkg

//--- core/itc_regs.sv
// Purpose: interrupt and trap control and status registers, apb slave
// Assumes: core pulses trap events for one cycle; ext irq pins are asynchronous
// Notes:   answers every apb access in its first access cycle (pready held high)
//
// Functional notes
// - accumulator overflow trap sets its A or B overflow flag
// - catastrophic accumulator overflow trap sets its A or B catastrophic flag only when the shared catastrophic trap enable is set
// - ordinary overflow traps only when that accumulator's trap enable is set
// - invalid accumulator shift math trap sets shift_acc_error
// - any math trap sets math_error; divide by zero also sets bit 6
// - address error trap sets address_error, held until software clears it
// - stack error trap sets stack_error
// - oscillator failure trap sets osc_failure; bit 0 reads zero
// - global_irq_enable resets to 1, gates interrupts but never traps
// - bit 14 of global control shows irq-disable instruction active
// - bit 13 of global control is the software trap enable
// - ext irq 0..2 detect falling edge if polarity 1, else rising
// - dma address error soft trap sets bit 5 of soft trap status
// - loop stack overflow soft trap sets bit 4; other bits read zero
// - software hard trap sets bit 0 of hard trap status
// - new priority level read-only in vector status bits 11-8
// - pending vector number read-only in bits 7-0
// - cpu priority is top bit joined above three low bits; top masks irqs
// - vector and priority latched together when an interrupt becomes pending
// - source flags set by peripherals, cleared by software
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps

module itc_regs
  import itc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // trap events from the core, one-cycle pulses
  input  wire logic        acc_a_ovf_i,
  input  wire logic        acc_b_ovf_i,
  input  wire logic        acc_a_cat_i,
  input  wire logic        acc_b_cat_i,
  input  wire logic        shift_err_i,
  input  wire logic        div0_err_i,
  input  wire logic        dmac_trap_i,
  input  wire logic        addr_err_i,
  input  wire logic        stack_err_i,
  input  wire logic        osc_fail_i,
  input  wire logic        dma_addr_err_i,
  input  wire logic        loop_ovf_i,
  input  wire logic        sw_hard_trap_i,
  input  wire logic        irq_disable_instr_active_active_i,
  // pending interrupt from the priority resolver
  input  wire logic        irq_pending_i,
  input  wire logic [7:0]  irq_vector_i,
  input  wire logic [3:0]  irq_level_i,
  input  wire logic [2:0]  cpu_priority_low_i,
  input  wire logic        cpu_priority_top_i,
  input  wire logic [2:0]  ext_irq_pin_i,
  // outputs to the core
  output logic             nesting_disable_o,
  output logic             irq_gate_o,
  output logic             software_trap_o,
  output logic             math_trap_o,
  output logic             acc_trap_o,
  output logic [2:0]       ext_irq_event_o,
  output logic [3:0]       cpu_priority_o
);

  // ************************************************************
  // apb decode
  // ************************************************************
  logic        acc_w;
  logic        wr_w;
  logic        hit_w;
  assign acc_w = psel_i & penable_i;
  assign wr_w  = acc_w & pwrite_i;

  function automatic logic wr_at(input logic [11:0] ofs);
    return wr_w && (paddr_i == ofs);
  endfunction

  // sticky update: hardware set wins over a software clear
  function automatic logic [15:0] sticky(input logic [15:0] cur,
                                         input logic [15:0] set,
                                         input logic        we,
                                         input logic [15:0] wd,
                                         input logic [15:0] mask);
    logic [15:0] v;
    v = we ? wd : cur;
    return (v | set) & mask;
  endfunction

  always_comb begin
    unique case (paddr_i)
      ITC_TRAP_CTRL_OFS, ITC_GLOBAL_OFS, ITC_SOFT_TRAP_OFS,
      ITC_HARD_TRAP_OFS, ITC_VECTOR_OFS, ITC_CPU_PRIO_OFS: hit_w = 1'b1;
      default: hit_w = 1'b0;
    endcase
  end

  // ************************************************************
  // ext irq pin sync and edge detect
  // ************************************************************
  logic [2:0]  pin_s1_r;
  logic [2:0]  pin_s2_r;
  logic [2:0]  pin_s3_r;
  logic [2:0]  pin_s1_nxt;
  logic [2:0]  pin_s2_nxt;
  logic [2:0]  pin_s3_nxt;
  logic [15:0] trap_r;
  logic [15:0] glob_r;
  logic [15:0] soft_r;
  logic [15:0] hard_r;
  logic [15:0] trap_nxt;
  logic [15:0] glob_nxt;
  logic [15:0] soft_nxt;
  logic [15:0] hard_nxt;
  logic [7:0]  vec_r;
  logic [7:0]  vec_nxt;
  logic [3:0]  lvl_r;
  logic [3:0]  lvl_nxt;
  logic        pend_d_r;
  logic        pend_d_nxt;
  logic [2:0]  ext_ev_r;
  logic [2:0]  ext_ev_nxt;
  logic [3:0]  prio_r;
  logic [3:0]  prio_nxt;
  logic        gate_r;
  logic        gate_nxt;
  logic        mtrap_r;
  logic        mtrap_nxt;
  logic        atrap_r;
  logic        atrap_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [15:0] tset_w;
  logic        ova_go_w;
  logic        ovb_go_w;
  logic        cov_go_w;

  // first stage only feeds the second
  always_comb begin
    pin_s1_nxt = ext_irq_pin_i;
    pin_s2_nxt = pin_s1_r;
    pin_s3_nxt = pin_s2_r;
    for (int i = 0; i < ITC_EXT_IRQS; i++) begin
      // polarity 1 picks the falling edge, 0 the rising edge
      ext_ev_nxt[i] = glob_r[i] ? (pin_s3_r[i] & ~pin_s2_r[i])
                                : (~pin_s3_r[i] & pin_s2_r[i]);
    end
  end

  // ************************************************************
  // trap qualification and status set terms
  // ************************************************************
  always_comb begin
    ova_go_w = acc_a_ovf_i & trap_r[ITC_OVA_TE_BIT];
    ovb_go_w = acc_b_ovf_i & trap_r[ITC_OVB_TE_BIT];
    cov_go_w = (acc_a_cat_i | acc_b_cat_i) & trap_r[ITC_COV_TE_BIT];
    tset_w = 16'h0000;
    tset_w[ITC_OVA_FLAG_BIT]  = ova_go_w;
    tset_w[ITC_OVB_FLAG_BIT]  = ovb_go_w;
    tset_w[ITC_COVA_FLAG_BIT] = acc_a_cat_i & trap_r[ITC_COV_TE_BIT];
    tset_w[ITC_COVB_FLAG_BIT] = acc_b_cat_i & trap_r[ITC_COV_TE_BIT];
    tset_w[ITC_SHIFT_ERR_BIT] = shift_err_i;
    tset_w[ITC_DIV0_ERR_BIT]  = div0_err_i;
    tset_w[ITC_MATH_ERR_BIT]  = shift_err_i | div0_err_i | ova_go_w
                              | ovb_go_w | cov_go_w;
    tset_w[ITC_DMAC_FLAG_BIT] = dmac_trap_i;
    tset_w[ITC_ADDR_ERR_BIT]  = addr_err_i;
    tset_w[ITC_STACK_ERR_BIT] = stack_err_i;
    tset_w[ITC_OSC_FAIL_BIT]  = osc_fail_i;
  end

  // ************************************************************
  // register next values
  // ************************************************************
  always_comb begin
    // flags stay until software writes zero; a write of one also sets
    trap_nxt = sticky(trap_r, tset_w, wr_at(ITC_TRAP_CTRL_OFS), pwdata_i[15:0],
                      ITC_TRAP_CTRL_MASK);
    soft_nxt = sticky(soft_r, {10'h000, dma_addr_err_i, loop_ovf_i, 4'h0},
                      wr_at(ITC_SOFT_TRAP_OFS), pwdata_i[15:0],
                      ITC_SOFT_TRAP_MASK);
    hard_nxt = sticky(hard_r, {15'h0000, sw_hard_trap_i},
                      wr_at(ITC_HARD_TRAP_OFS), pwdata_i[15:0],
                      ITC_HARD_TRAP_MASK);
    glob_nxt = wr_at(ITC_GLOBAL_OFS) ? (pwdata_i[15:0] & ITC_GLOBAL_MASK) : glob_r;
    glob_nxt[ITC_IRQ_DISABLE_INSTR_ACTIVE_BIT] = irq_disable_instr_active_active_i; // status mirror, not writable
    // latch vector and level on the rising edge of pending
    pend_d_nxt = irq_pending_i;
    vec_nxt = vec_r;
    lvl_nxt = lvl_r;
    if (irq_pending_i && !pend_d_r) begin
      vec_nxt = irq_vector_i;
      lvl_nxt = irq_level_i;
    end
    prio_nxt = {cpu_priority_top_i, cpu_priority_low_i};
    // user irqs need enable set and top priority bit clear
    gate_nxt  = glob_r[ITC_GIE_BIT] & ~cpu_priority_top_i;
    mtrap_nxt = tset_w[ITC_MATH_ERR_BIT];  // any qualified math trap
    atrap_nxt = ova_go_w | ovb_go_w | cov_go_w;
    rdata_nxt = 32'h0000_0000;
    err_nxt   = psel_i & ~penable_i & ~hit_w;  // taken at setup so it stands in access
    unique case (paddr_i)
      ITC_TRAP_CTRL_OFS: rdata_nxt[15:0] = trap_nxt;
      ITC_GLOBAL_OFS:    rdata_nxt[15:0] = glob_nxt;
      ITC_SOFT_TRAP_OFS: rdata_nxt[15:0] = soft_nxt;
      ITC_HARD_TRAP_OFS: rdata_nxt[15:0] = hard_nxt;
      ITC_VECTOR_OFS:    rdata_nxt[15:0] = {4'h0, lvl_nxt, vec_nxt};
      ITC_CPU_PRIO_OFS:  rdata_nxt[15:0] = {12'h000, prio_nxt};
      default:           rdata_nxt = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  // pin synchroniser; the first stage feeds nothing but the second
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      pin_s3_r <= pin_s3_nxt;
    end
  end

  // software visible control words and sticky status
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      trap_r   <= ITC_TRAP_CTRL_RST;
      glob_r   <= ITC_GLOBAL_RST;  // enable comes up set
      soft_r   <= 16'h0000;
      hard_r   <= 16'h0000;
    end else begin
      trap_r   <= trap_nxt;
      glob_r   <= glob_nxt;
      soft_r   <= soft_nxt;
      hard_r   <= hard_nxt;
    end
  end

  // latched vector and level, with the pending edge detector
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      vec_r    <= ITC_VEC_RST;
      lvl_r    <= ITC_PRIO_RST;
      pend_d_r <= 1'b0;
    end else begin
      vec_r    <= vec_nxt;
      lvl_r    <= lvl_nxt;
      pend_d_r <= pend_d_nxt;
    end
  end

  // strobes and levels towards the core, all from flops
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ext_ev_r <= 3'h0;
      prio_r   <= 4'h0;
      gate_r   <= 1'b0;
      mtrap_r  <= 1'b0;
      atrap_r  <= 1'b0;
    end else begin
      ext_ev_r <= ext_ev_nxt;
      prio_r   <= prio_nxt;
      gate_r   <= gate_nxt;
      mtrap_r  <= mtrap_nxt;
      atrap_r  <= atrap_nxt;
    end
  end

  // bus answer; captured at the setup edge so it stands in the access cycle
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_r  <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // read data is registered, so it reflects state one edge after setup
  assign prdata_o          = rdata_r;
  assign pslverr_o         = err_r;
  assign pready_o          = 1'b1;
  assign nesting_disable_o = trap_r[ITC_NEST_DIS_BIT];
  assign software_trap_o   = glob_r[ITC_SOFTWARE_TRAP_EN_BIT];
  assign irq_gate_o        = gate_r;
  assign math_trap_o       = mtrap_r;
  assign acc_trap_o        = atrap_r;
  assign ext_irq_event_o   = ext_ev_r;
  assign cpu_priority_o    = prio_r;

  // ************************************************************
  // assertions
  // ************************************************************
  // address flag only rises on its event or a software write
  sticky_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(trap_r[ITC_ADDR_ERR_BIT]) |-> $past(addr_err_i) || $past(wr_w))
    else $error("address error flag rose without cause");
  // global enable leaves reset set
  gie_reset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> glob_r[ITC_GIE_BIT])
    else $error("global enable not set after reset");
  // a disabled overflow of accumulator a never raises its flag
  ova_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (acc_a_ovf_i && !trap_r[ITC_OVA_TE_BIT] && !wr_w) |=> !$rose(trap_r[ITC_OVA_FLAG_BIT]))
    else $error("overflow A flagged while disabled");
  // catastrophic B flag stays quiet while its trap is disabled
  cat_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (acc_b_cat_i && !trap_r[ITC_COV_TE_BIT] && !wr_w) |=> !$rose(trap_r[ITC_COVB_FLAG_BIT]))
    else $error("catastrophic B flagged while disabled");
  // divide by zero records its cause and the math error
  math_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    div0_err_i |=> trap_r[ITC_MATH_ERR_BIT] && trap_r[ITC_DIV0_ERR_BIT])
    else $error("divide by zero not recorded");
  // falling edge on pin 0 under polarity 1 gives an event
  edge_fall_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (glob_r[0] && $fell(pin_s2_r[0])) |=> ext_irq_event_o[0])
    else $error("falling edge missed");
  // rising edge on pin 1 under polarity 0 gives an event
  edge_rise_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!glob_r[1] && $rose(pin_s2_r[1])) |=> ext_irq_event_o[1])
    else $error("rising edge missed");
  // vector taken on the rise of pending
  vec_latch_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(irq_pending_i) && !pend_d_r |=> vec_r == $past(irq_vector_i))
    else $error("vector not latched");
  // vector and level hold until a new interrupt becomes pending
  vec_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(irq_pending_i && !pend_d_r) |=> $stable(vec_r) && $stable(lvl_r))
    else $error("vector changed without a new pending");
  // cpu priority is the top bit joined above the low bits
  prio_join_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ##1 cpu_priority_o == $past({cpu_priority_top_i, cpu_priority_low_i}))
    else $error("priority join wrong");
  // user irqs blocked by the top priority bit or a cleared enable
  gate_block_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cpu_priority_top_i || !glob_r[ITC_GIE_BIT]) |=> !irq_gate_o)
    else $error("user interrupts not blocked");
  // irq-disable status follows the core
  irq_disable_instr_active_mirror_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ##1 glob_r[ITC_IRQ_DISABLE_INSTR_ACTIVE_BIT] == $past(irq_disable_instr_active_active_i))
    else $error("irq disable status not mirrored");
  // loop stack overflow recorded, bit 0 stays zero
  soft_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    loop_ovf_i |=> soft_r[ITC_LOOP_OVF_BIT] && !soft_r[0])
    else $error("loop overflow not recorded");
  // dma address soft trap recorded
  dma_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    dma_addr_err_i |=> soft_r[ITC_DMA_ADDR_BIT])
    else $error("dma address trap not recorded");
  // hard trap flag holds until software writes
  hard_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sw_hard_trap_i |=> hard_r[ITC_SW_HARD_BIT] ##1 hard_r[ITC_SW_HARD_BIT] || $past(wr_w))
    else $error("hard trap flag lost");
  // unmapped access is refused within its own access cycle
  err_resp_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (psel_i && penable_i && !hit_w) |-> pslverr_o)
    else $error("unmapped access not refused");

endmodule // itc_regs

//--- tb/itc_core_model.sv
// Purpose: processor core stand-in that raises trap events and pending irqs
// Assumes: every event is a one-cycle pulse launched just after a rising edge
// Notes:   a dropped vector bus is scrambled, never left at its last value
`timescale 1ns/1ps

module itc_core_model (
  input  wire logic        mclk_i,
  output logic [12:0]      trap_ev_o,
  output logic             irq_disable_instr_active_o,
  output logic             pend_o,
  output logic [7:0]       vec_o,
  output logic [3:0]       lvl_o,
  output logic [2:0]       prio_low_o,
  output logic             prio_top_o
);
  // ************************************************************
  // idle state and event tasks
  // ************************************************************
  initial begin
    trap_ev_o = '0;
    irq_disable_instr_active_o = 1'b0;
    pend_o = 1'b0;
    vec_o = 8'h00;
    lvl_o = 4'h0;
    prio_low_o = 3'h0;
    prio_top_o = 1'b0;
  end

  // a source sets its flag with one pulse; software does the clearing
  task automatic raise(input int idx);
    @(posedge mclk_i);
    trap_ev_o <= 13'h0001 << idx;
    @(posedge mclk_i);
    trap_ev_o <= '0;
  endtask

  // vector and level move on after the rise, so only a latch keeps them
  task automatic post(input logic [7:0] v, input logic [3:0] l);
    @(posedge mclk_i);
    pend_o <= 1'b1;
    vec_o <= v;
    lvl_o <= l;
    @(posedge mclk_i);
    vec_o <= ~v;
    lvl_o <= ~l;
  endtask

  task automatic drop();
    @(posedge mclk_i);
    pend_o <= 1'b0;
    vec_o <= ~vec_o;
  endtask

  // priority bits come from the status and core control registers
  task automatic set_prio(input logic [2:0] lo, input logic top, input logic di);
    @(posedge mclk_i);
    prio_low_o <= lo;
    prio_top_o <= top;
    irq_disable_instr_active_o <= di;
  endtask
endmodule // itc_core_model

//--- tb/itc_regs_tb.sv
// Purpose: self-checking bench for the trap and interrupt control registers
// Assumes: apb slave answers whenever pready is sampled high
// Notes:   expected words come from the bit map, never from the dut
`timescale 1ns/1ps

module itc_regs_tb
  import itc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err, nest, gate, swt, atrap, mtrap, irq_disable_instr_active, pend, ptop;
  logic [2:0]  pin = '0;
  logic [2:0]  ev, plow;
  logic [3:0]  prio, lvl;
  logic [7:0]  vec;
  logic [12:0] tev;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          acc_n = 0;
  int          math_n = 0;
  // flag words per event: acc a, acc b, cat a, cat b, shift, div0, dmac, addr, stack, osc,
  // dma addr, loop, sw hard; math error rides on the math and accumulator traps
  localparam logic [15:0] EXP [13] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
    16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002, 16'h0020, 16'h0010, 16'h0001};

  itc_regs dut (
    .mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .acc_a_ovf_i(tev[0]), .acc_b_ovf_i(tev[1]), .acc_a_cat_i(tev[2]),
    .acc_b_cat_i(tev[3]), .shift_err_i(tev[4]), .div0_err_i(tev[5]), .dmac_trap_i(tev[6]),
    .addr_err_i(tev[7]), .stack_err_i(tev[8]), .osc_fail_i(tev[9]),
    .dma_addr_err_i(tev[10]), .loop_ovf_i(tev[11]), .sw_hard_trap_i(tev[12]),
    .irq_disable_instr_active_active_i(irq_disable_instr_active), .irq_pending_i(pend), .irq_vector_i(vec), .irq_level_i(lvl),
    .cpu_priority_low_i(plow), .cpu_priority_top_i(ptop), .ext_irq_pin_i(pin),
    .nesting_disable_o(nest), .irq_gate_o(gate), .software_trap_o(swt),
    .math_trap_o(mtrap), .acc_trap_o(atrap), .ext_irq_event_o(ev), .cpu_priority_o(prio));

  itc_core_model core (
    .mclk_i(mclk), .trap_ev_o(tev), .irq_disable_instr_active_o(irq_disable_instr_active), .pend_o(pend), .vec_o(vec),
    .lvl_o(lvl), .prio_low_o(plow), .prio_top_o(ptop));

  // ************************************************************
  // clock, watchdog and shared tasks
  // ************************************************************
  always #5 mclk = ~mclk;

  // counts accumulator and math trap pulses; a hang ends in the same report
  always @(posedge mclk) begin
    cyc++;
    if (atrap === 1'b1) acc_n++;
    if (mtrap === 1'b1) math_n++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rchk("trap reset", ITC_TRAP_CTRL_OFS, 32'h0);
    rchk("global reset", ITC_GLOBAL_OFS, 32'h8000);
    rchk("soft reset", ITC_SOFT_TRAP_OFS, 32'h0);
    rchk("hard reset", ITC_HARD_TRAP_OFS, 32'h0);
    rchk("vector reset", ITC_VECTOR_OFS, 32'h0);
    rchk("unmapped", 12'h020, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask

  // all ones written: unimplemented bits and read-only fields must stay zero
  task automatic t_access();
    apb(1'b1, ITC_TRAP_CTRL_OFS, 32'hffff);
    rchk("trap ones", ITC_TRAP_CTRL_OFS, 32'hfffe);
    chk("nesting on", 32'h1, {31'h0, nest});
    apb(1'b1, ITC_GLOBAL_OFS, 32'hffff);
    rchk("global ones", ITC_GLOBAL_OFS, 32'ha007);
    chk("sw trap on", 32'h1, {31'h0, swt});
    apb(1'b1, ITC_SOFT_TRAP_OFS, 32'hffff);
    rchk("soft ones", ITC_SOFT_TRAP_OFS, 32'h0030);
    apb(1'b1, ITC_HARD_TRAP_OFS, 32'hffff);
    rchk("hard ones", ITC_HARD_TRAP_OFS, 32'h0001);
    apb(1'b1, ITC_VECTOR_OFS, 32'hffff);
    rchk("vector ro", ITC_VECTOR_OFS, 32'h0);
    apb(1'b1, ITC_TRAP_CTRL_OFS, 32'h0);
    apb(1'b1, ITC_SOFT_TRAP_OFS, 32'h0);
    apb(1'b1, ITC_HARD_TRAP_OFS, 32'h0);
    apb(1'b1, ITC_GLOBAL_OFS, 32'h8000);
    rchk("trap zero", ITC_TRAP_CTRL_OFS, 32'h0);
    chk("nesting off", 32'h0, {31'h0, nest});
    chk("sw trap off", 32'h0, {31'h0, swt});
    $display("test access done");
  endtask

  // every event with the trap enables set, then the accumulator ones without
  task automatic t_traps();
    logic [11:0] a;
    logic [31:0] base;
    apb(1'b1, ITC_TRAP_CTRL_OFS, 32'h0700);
    for (int i = 0; i < 13; i++) begin
      a = (i < 10) ? ITC_TRAP_CTRL_OFS : (i < 12) ? ITC_SOFT_TRAP_OFS : ITC_HARD_TRAP_OFS;
      base = (i < 10) ? 32'h0700 : 32'h0;
      core.raise(i);
      rchk("flag set", a, base | {16'h0, EXP[i]});
      rchk("flag held", a, base | {16'h0, EXP[i]});
      apb(1'b1, a, base);
    end
    chk("qualified acc traps", 32'd4, acc_n);
    chk("math traps", 32'd6, math_n);
    apb(1'b1, ITC_TRAP_CTRL_OFS, 32'h0);
    for (int i = 0; i < 4; i++) core.raise(i);
    repeat (3) @(posedge mclk);
    chk("masked acc traps", 32'd4, acc_n);
    chk("masked math traps", 32'd6, math_n);
    rchk("masked flags", ITC_TRAP_CTRL_OFS, 32'h0);
    apb(1'b1, ITC_TRAP_CTRL_OFS, 32'h0);
    $display("test traps done");
  endtask

  // both edges on each pin under both polarities; only the chosen edge counts
  task automatic t_ext();
    logic seen;
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        apb(1'b1, ITC_GLOBAL_OFS, 32'h8000 | (p << i));
        for (int t = 0; t < 2; t++) begin
          seen = 1'b0;
          @(posedge mclk);
          pin[i] <= ~pin[i];
          repeat (8) begin
            @(posedge mclk);
            if (ev[i] === 1'b1) seen = 1'b1;
          end
          chk("edge event", {31'h0, (p == 0) == (pin[i] === 1'b1)}, {31'h0, seen});
        end
      end
    end
    apb(1'b1, ITC_GLOBAL_OFS, 32'h8000);
    $display("test ext done");
  endtask

  task automatic t_vec_prio();
    core.post(8'h08, 4'h5);
    rchk("vector latch", ITC_VECTOR_OFS, 32'h0508);
    core.drop();
    core.post(8'hff, 4'hf);
    rchk("vector top", ITC_VECTOR_OFS, 32'h0fff);
    core.drop();
    core.set_prio(3'h5, 1'b0, 1'b1);
    repeat (3) @(posedge mclk);
    chk("cpu prio low", 32'h5, {28'h0, prio});
    chk("gate open", 32'h1, {31'h0, gate});
    rchk("irq_disable_instr_active mirror", ITC_GLOBAL_OFS, 32'hc000);
    core.set_prio(3'h5, 1'b1, 1'b0);
    repeat (3) @(posedge mclk);
    chk("cpu prio top", 32'hd, {28'h0, prio});
    chk("gate top", 32'h0, {31'h0, gate});
    rchk("prio reg", ITC_CPU_PRIO_OFS, 32'hd);
    core.set_prio(3'h2, 1'b0, 1'b0);
    apb(1'b1, ITC_GLOBAL_OFS, 32'h0);
    repeat (3) @(posedge mclk);
    chk("gate global off", 32'h0, {31'h0, gate});
    $display("test vector and priority done");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_access();
    t_traps();
    t_ext();
    t_vec_prio();
    final_report();
  end
endmodule // itc_regs_tb
